// ---- shared/host_port_pkg.sv ----
// constants and types shared by both ends of the parallel disk host port
// assumes one 40 MHz core clock drives every flip-flop on both ends
package host_port_pkg;
	localparam int unsigned  DATA_W         = 16;          // full data bus width
	localparam int unsigned  REG_W          = 8;           // register transfers use low byte
	localparam int unsigned  ADDR_W         = 3;           // register address lines
	localparam int unsigned  CLK_PERIOD_PS  = 25000;       // 40 MHz core clock
	localparam int unsigned  INTRQ_CLR_NS   = 400;         // longest interrupt clear time
	// longest time rounds down to whole cycles
	localparam int unsigned  INTRQ_CLR_CYC  = (INTRQ_CLR_NS * 1000) / CLK_PERIOD_PS;
	localparam logic [2:0]   ADDR_DATA      = 3'h0;        // data register
	localparam logic [2:0]   ADDR_DRVHEAD   = 3'h6;        // drive/head register
	localparam logic [2:0]   ADDR_STATUS    = 3'h7;        // status read / command write
	localparam int unsigned  DRV_BIT        = 4;           // drive select bit in drive/head
	localparam int unsigned  NIEN_BIT       = 1;           // interrupt disable in control
	localparam logic [7:0]   RST_STATUS     = 8'h50;       // status value after reset
	localparam logic [7:0]   RST_DRVHEAD    = 8'ha0;       // drive/head value after reset
	localparam int unsigned  PIO_MODES      = 5;           // pio modes 0..4
	localparam int unsigned  DMA_MODES      = 3;           // dma modes 0..2
	// strobe state lengths in core cycles per pio and dma mode (strobe stays active at least one wait cycle more)
	localparam logic [3:0]   PIO_ACT_CYC [PIO_MODES] = '{4'h7, 4'h5, 4'h4, 4'h3, 4'h2};
	localparam logic [3:0]   DMA_ACT_CYC [DMA_MODES] = '{4'ha, 4'h4, 4'h3};
	typedef enum logic [2:0] {
		H_IDLE   = 3'b000,
		H_SETUP  = 3'b001,
		H_STROBE = 3'b011,
		H_WAIT   = 3'b010,
		H_HOLD   = 3'b110
	} host_state_t;
endpackage

// ---- shared/host_port_if.sv ----
// pin bundle between host controller and device end of the disk port
// two-way and tri-state pins carry level, drive and active-low enable signals
`timescale 1ns/100ps
`default_nettype none
interface host_port_if;
	logic [15:0] host_data_bus_h;        // host drive value
	logic        data_oe_n_h;            // host drives data when low
	logic [15:0] host_data_bus_d;        // device drive value
	logic        data_oe_n_d;            // device drives data when low
	logic [15:0] host_data_bus;          // resolved bus level
	logic [2:0]  register_address_lines; // register select
	logic        cs0_n;                  // chip select 0
	logic        cs1_n;                  // chip select 1
	logic        host_write_strobe_n;    // write strobe
	logic        host_read_strobe_n;     // read strobe
	logic        reset_n;                // host reset
	logic        dmack_n;                // dma acknowledge
	logic        csel;                   // slave when high
	logic        iordy;                  // device ready
	logic        dmarq;                  // dma request value
	logic        dmarq_oe_n;             // dmarq driven when low
	logic        intrq;                  // interrupt value
	logic        intrq_oe_n;             // intrq driven when low
	logic        iois16_n;               // word cycle marker
	logic        pdiag_n_o;              // passed diagnostics value
	logic        pdiag_oe_n;             // pdiag driven when low
	logic        pdiag_n;                // resolved pdiag level
	// resolve bus levels; undriven lines read as pulled high
	assign host_data_bus = !data_oe_n_d ? host_data_bus_d :
		(!data_oe_n_h ? host_data_bus_h : 16'hffff);
	assign pdiag_n = pdiag_oe_n ? 1'b1 : pdiag_n_o;
	modport host (
		output host_data_bus_h, data_oe_n_h, register_address_lines, cs0_n, cs1_n,
		output host_write_strobe_n, host_read_strobe_n, reset_n, dmack_n, csel,
		input  host_data_bus, iordy, dmarq, dmarq_oe_n, intrq, intrq_oe_n, iois16_n, pdiag_n
	);
	modport device (
		output host_data_bus_d, data_oe_n_d, iordy, dmarq, dmarq_oe_n, intrq, intrq_oe_n,
		output iois16_n, pdiag_n_o, pdiag_oe_n,
		input  host_data_bus, register_address_lines, cs0_n, cs1_n, host_write_strobe_n,
		input  host_read_strobe_n, reset_n, dmack_n, csel, pdiag_n
	);
endinterface
`default_nettype wire

// ---- verilog/strobe_edge.sv ----
// edge finder for one host strobe sampled on the core clock
// assumes the strobe is already synchronous to i_core_clk
`timescale 1ns/100ps
`default_nettype none
module strobe_edge (
	input  wire logic i_core_clk,  // core clock
	input  wire logic i_rst,       // async reset, high
	input  wire logic i_strobe_n,  // active-low strobe
	output logic      o_fall,      // asserted this cycle
	output logic      o_rise       // negated this cycle
);
	typedef struct packed {
		logic prev;
	} edge_state_t;
	edge_state_t s_q;
	edge_state_t s_d;

	// remember last level; idle level is high
	always_comb begin
		s_d      = s_q;
		s_d.prev = i_strobe_n;
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= '{prev: 1'b1};
		end else begin
			s_q <= s_d;
		end
	end
	assign o_fall = s_q.prev & ~i_strobe_n;
	assign o_rise = ~s_q.prev & i_strobe_n;
endmodule // strobe_edge
`default_nettype wire

// ---- verilog/disk_device_port.sv ----
// device end of the parallel disk host port: task file, pio and dma data path
// assumes host pins synchronous to i_core_clk; back end fills/drains words
`timescale 1ns/100ps
`default_nettype none
module disk_device_port (
	input  wire logic        i_core_clk,     // core clock
	input  wire logic        i_rst,          // async reset, high
	host_port_if.device      bus,            // host pins
	output logic             o_cmd_valid,    // command written, one pulse
	output logic [7:0]       o_cmd,          // last command byte
	input  wire logic        i_data_ready,   // back end can take or give a word
	input  wire logic [15:0] i_rd_word,      // word for host reads
	output logic             o_wr_valid,     // host word written, one pulse
	output logic             o_rd_take,      // host took read word, one pulse
	output logic [15:0]      o_wr_word,      // word written by host
	input  wire logic        i_dma_active,   // dma command in progress
	input  wire logic        i_dma_more,     // more dma words remain
	input  wire logic        i_irq_set,      // back end raises interrupt, pulse
	input  wire logic [7:0]  i_status,       // status from back end
	input  wire logic        i_diag_done,    // self-diagnostic finished
	output logic             o_is_slave,     // captured configuration
	output logic             o_host_reset    // host reset seen, level
);
	typedef struct packed {
		logic [15:0] rd_data;
		logic [15:0] wr_word;
		logic [7:0]  cmd;
		logic [7:0]  drvhead;
		logic        nien;
		logic        irq;
		logic        slave;
		logic        dmarq;
		logic        dreq_wait;
		logic        cmd_valid;
		logic        wr_valid;
		logic        rd_take;
		logic        driving;
		logic        word_cyc;
		logic        diag_sent;
	} dev_state_t;
	dev_state_t s_q;
	dev_state_t s_d;

	logic rd_fall;
	logic rd_rise;
	logic wr_fall;
	logic wr_rise;
	logic cmd_sel;
	logic ctl_sel;
	logic dma_cyc;
	logic me;

	////////////////////////////////////////////////////////////////////////////
	// strobe edges
	strobe_edge u_rd_edge (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_strobe_n (bus.host_read_strobe_n),
		.o_fall     (rd_fall),
		.o_rise     (rd_rise)
	);
	strobe_edge u_wr_edge (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_strobe_n (bus.host_write_strobe_n),
		.o_fall     (wr_fall),
		.o_rise     (wr_rise)
	);

	////////////////////////////////////////////////////////////////////////////
	// decode: cs0 alone is the command block, cs1 alone the control block
	always_comb begin
		cmd_sel = ~bus.cs0_n & bus.cs1_n;
		ctl_sel = bus.cs0_n & ~bus.cs1_n;
		dma_cyc = ~bus.dmack_n & i_dma_active;
		// drive/head select bit must match our address; writes to it always land
		me      = (s_q.drvhead[host_port_pkg::DRV_BIT] == s_q.slave);
	end

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		s_d           = s_q;
		s_d.cmd_valid = 1'b0;
		s_d.wr_valid  = 1'b0;
		s_d.rd_take   = 1'b0;
		s_d.slave     = bus.csel;
		// read: present data on the falling read strobe
		if (rd_fall && ((cmd_sel && me) || dma_cyc)) begin
			s_d.driving  = 1'b1;
			s_d.word_cyc = dma_cyc || (bus.register_address_lines == host_port_pkg::ADDR_DATA);
			if (s_d.word_cyc) begin
				s_d.rd_data = i_rd_word;
			end else if (bus.register_address_lines == host_port_pkg::ADDR_STATUS) begin
				s_d.rd_data = {8'h00, i_status};
			end else if (bus.register_address_lines == host_port_pkg::ADDR_DRVHEAD) begin
				s_d.rd_data = {8'h00, s_q.drvhead};
			end else begin
				s_d.rd_data = 16'h0000;
			end
		end
		if (rd_rise && s_q.driving) begin
			s_d.driving = 1'b0;
			s_d.rd_take = s_q.word_cyc;
			s_d.word_cyc = 1'b0;
			// status read acknowledges the interrupt at strobe negation
			if (!s_q.word_cyc && !dma_cyc &&
			    bus.register_address_lines == host_port_pkg::ADDR_STATUS) begin
				s_d.irq = 1'b0;
			end
		end
		// write: capture data on the rising write strobe
		if (wr_fall) begin
			// a deselected drive must not claim a word cycle
			s_d.word_cyc = dma_cyc || (cmd_sel && me &&
			               bus.register_address_lines == host_port_pkg::ADDR_DATA);
		end
		if (wr_rise) begin
			if (dma_cyc || (cmd_sel && me &&
			    bus.register_address_lines == host_port_pkg::ADDR_DATA)) begin
				s_d.wr_word  = bus.host_data_bus;
				s_d.wr_valid = 1'b1;
			end else if (cmd_sel && bus.register_address_lines == host_port_pkg::ADDR_DRVHEAD) begin
				s_d.drvhead = bus.host_data_bus[7:0];
			end else if (cmd_sel && me &&
			             bus.register_address_lines == host_port_pkg::ADDR_STATUS) begin
				s_d.cmd       = bus.host_data_bus[7:0];
				s_d.cmd_valid = 1'b1;
				s_d.irq       = 1'b0;
			end else if (ctl_sel && bus.register_address_lines == host_port_pkg::ADDR_STATUS - 3'h1) begin
				s_d.nien = bus.host_data_bus[host_port_pkg::NIEN_BIT];
			end
			s_d.word_cyc = 1'b0;
		end
		// a new interrupt event wins over a clear in the same cycle
		if (i_irq_set) begin
			s_d.irq = 1'b1;
		end
		// dma request handshake: drop on dmack, raise again for more data
		if (!i_dma_active) begin
			s_d.dmarq     = 1'b0;
			s_d.dreq_wait = 1'b0;
		end else if (s_q.dmarq && !bus.dmack_n) begin
			s_d.dmarq     = 1'b0;
			s_d.dreq_wait = 1'b1;
		end else if (s_q.dreq_wait && bus.dmack_n) begin
			s_d.dreq_wait = 1'b0;
		end else if (!s_q.dmarq && !s_q.dreq_wait && i_data_ready && i_dma_more) begin
			s_d.dmarq = 1'b1;
		end
		if (i_diag_done && s_q.slave) begin
			s_d.diag_sent = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register; host reset clears the task file like a hard reset
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q         <= '0;
			s_q.drvhead <= host_port_pkg::RST_DRVHEAD;
		end else if (!bus.reset_n) begin
			s_q         <= '0;
			s_q.drvhead <= host_port_pkg::RST_DRVHEAD;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pins; enables are active low
	always_comb begin
		bus.host_data_bus_d = s_q.rd_data;
		bus.data_oe_n_d     = ~(s_q.driving && !bus.host_read_strobe_n);
		// stretch data cycles while the back end has nothing to give or take
		bus.iordy           = ~((s_q.driving || !bus.host_write_strobe_n) &&
		                        s_q.word_cyc && !i_data_ready);
		bus.dmarq           = s_q.dmarq;
		bus.dmarq_oe_n      = ~(i_dma_active && me);
		bus.intrq           = s_q.irq & me;
		bus.intrq_oe_n      = s_q.nien;
		bus.iois16_n        = ~s_q.word_cyc;
		bus.pdiag_n_o       = 1'b0;
		bus.pdiag_oe_n      = ~s_q.diag_sent;
	end
	assign o_cmd_valid  = s_q.cmd_valid;
	assign o_cmd        = s_q.cmd;
	assign o_wr_valid   = s_q.wr_valid;
	assign o_rd_take    = s_q.rd_take;
	assign o_wr_word    = s_q.wr_word;
	assign o_is_slave   = s_q.slave;
	assign o_host_reset = ~bus.reset_n;
endmodule // disk_device_port
`default_nettype wire

// ---- verilog/disk_host_port.sv ----
// host controller end: runs one pio register/data cycle or dma word per request
// assumes a single requester that waits for o_done before the next request
`timescale 1ns/100ps
`default_nettype none
module disk_host_port (
	input  wire logic        i_core_clk,   // core clock
	input  wire logic        i_rst,        // async reset, high
	host_port_if.host        bus,          // device pins
	input  wire logic        i_req,        // start a cycle, pulse
	input  wire logic        i_write,      // 1 write, 0 read
	input  wire logic        i_dma,        // dma word when high
	input  wire logic        i_ctl,        // control block (cs1) access
	input  wire logic [2:0]  i_addr,       // register address
	input  wire logic [15:0] i_wdata,      // write data
	input  wire logic [2:0]  i_mode,       // timing mode
	input  wire logic        i_dev_reset,  // hold device in reset
	input  wire logic        i_slave_cfg,  // configuration select
	output logic             o_busy,       // cycle in progress
	output logic             o_done,       // cycle finished, pulse
	output logic [15:0]      o_rdata,      // read data
	output logic             o_irq,        // device interrupt level
	output logic             o_dmarq,      // device requests dma
	output logic             o_diag_ok     // slave passed diagnostics
);
	typedef struct packed {
		host_port_pkg::host_state_t st;
		logic [3:0]  cnt;
		logic        write;
		logic        dma;
		logic        ctl;
		logic [2:0]  addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic        done;
	} host_regs_t;
	host_regs_t s_q;
	host_regs_t s_d;
	logic [3:0] act_cyc;
	logic       strobe;

	////////////////////////////////////////////////////////////////////////////
	// strobe length per mode; out-of-range modes fall back to the slowest
	always_comb begin
		if (s_q.dma) begin
			act_cyc = (i_mode < 3'(host_port_pkg::DMA_MODES)) ?
				host_port_pkg::DMA_ACT_CYC[i_mode[1:0]] : host_port_pkg::DMA_ACT_CYC[0];
		end else begin
			act_cyc = (i_mode < 3'(host_port_pkg::PIO_MODES)) ?
				host_port_pkg::PIO_ACT_CYC[i_mode] : host_port_pkg::PIO_ACT_CYC[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// cycle sequencer
	always_comb begin
		s_d      = s_q;
		s_d.done = 1'b0;
		case (s_q.st)
			host_port_pkg::H_IDLE: begin
				if (i_req) begin
					s_d.st    = host_port_pkg::H_SETUP;
					s_d.write = i_write;
					s_d.dma   = i_dma;
					s_d.ctl   = i_ctl;
					s_d.addr  = i_addr;
					s_d.wdata = i_wdata;
				end
			end
			host_port_pkg::H_SETUP: begin
				s_d.st  = host_port_pkg::H_STROBE;
				s_d.cnt = act_cyc;
			end
			host_port_pkg::H_STROBE: begin
				if (s_q.cnt > 4'h1) begin
					s_d.cnt = s_q.cnt - 4'h1;
				end else begin
					s_d.st = host_port_pkg::H_WAIT;
				end
			end
			host_port_pkg::H_WAIT: begin
				// device stretches the cycle with iordy low
				if (bus.iordy) begin
					s_d.st    = host_port_pkg::H_HOLD;
					s_d.rdata = s_q.dma ? bus.host_data_bus :
						(bus.iois16_n ? {8'h00, bus.host_data_bus[7:0]} : bus.host_data_bus);
				end
			end
			host_port_pkg::H_HOLD: begin
				s_d.st   = host_port_pkg::H_IDLE;
				s_d.done = 1'b1;
			end
			default: s_d.st = host_port_pkg::H_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pins
	assign strobe = (s_q.st == host_port_pkg::H_STROBE) || (s_q.st == host_port_pkg::H_WAIT);
	always_comb begin
		bus.register_address_lines = s_q.addr;
		// dma words hold both selects asserted; the device decodes neither block then
		bus.cs0_n = ~((s_q.st != host_port_pkg::H_IDLE) && (!s_q.ctl || s_q.dma));
		bus.cs1_n = ~((s_q.st != host_port_pkg::H_IDLE) && (s_q.ctl || s_q.dma));
		bus.dmack_n = ~((s_q.st != host_port_pkg::H_IDLE) && s_q.dma);
		bus.host_write_strobe_n = ~(strobe && s_q.write);
		bus.host_read_strobe_n  = ~(strobe && !s_q.write);
		bus.host_data_bus_h = s_q.wdata;
		bus.data_oe_n_h     = ~((s_q.st != host_port_pkg::H_IDLE) && s_q.write);
		bus.reset_n         = ~i_dev_reset;
		bus.csel            = i_slave_cfg;
	end
	assign o_busy    = (s_q.st != host_port_pkg::H_IDLE);
	assign o_done    = s_q.done;
	assign o_rdata   = s_q.rdata;
	assign o_irq     = ~bus.intrq_oe_n & bus.intrq;
	assign o_dmarq   = ~bus.dmarq_oe_n & bus.dmarq;
	assign o_diag_ok = ~bus.pdiag_n;
endmodule // disk_host_port
`default_nettype wire

// ---- verification/ata_host_port_asserts.sv ----
// pin-level checker for the disk host port, watching both ends at once
// assumes one core clock; the bench instantiates it beside the interface
`timescale 1ns/100ps
`default_nettype none
module ata_host_port_checker (
	input wire logic       i_core_clk,             // core clock
	input wire logic       i_rst,                  // async reset, high
	input wire logic       data_oe_n_d,            // device drives data when low
	input wire logic [2:0] register_address_lines, // register select
	input wire logic       cs0_n,                  // chip select 0
	input wire logic       host_write_strobe_n,    // write strobe
	input wire logic       host_read_strobe_n,     // read strobe
	input wire logic       dmack_n,                // dma acknowledge
	input wire logic       csel,                   // slave when high
	input wire logic       iordy,                  // device ready
	input wire logic       dmarq,                  // dma request
	input wire logic       dmarq_oe_n,             // dmarq enable
	input wire logic       intrq,                  // interrupt
	input wire logic       intrq_oe_n,             // intrq enable
	input wire logic       iois16_n,               // word marker
	input wire logic       pdiag_n                 // resolved pdiag
);
	localparam int CLR_MAX = host_port_pkg::INTRQ_CLR_CYC; // 400 ns rounded down, stricter
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	////////////////////////////////////////////////////////////////////////////////
	// end of a selected status read or command write while intrq is raised
	sequence s_status_read;
		$rose(host_read_strobe_n) && !cs0_n && register_address_lines == host_port_pkg::ADDR_STATUS;
	endsequence
	sequence s_cmd_write;
		$rose(host_write_strobe_n) && !cs0_n && register_address_lines == host_port_pkg::ADDR_STATUS;
	endsequence
	sequence s_irq_up;
		intrq && !intrq_oe_n;
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	a_status_clears: assert property (s_status_read ##0 s_irq_up |-> ##[1:CLR_MAX] !intrq)
		else $error("intrq not cleared after status read");
	a_cmd_clears: assert property (s_cmd_write ##0 s_irq_up |-> ##[1:CLR_MAX] !intrq)
		else $error("intrq not cleared after command write");
	a_read_drive: assert property ($fell(host_read_strobe_n) && (!cs0_n || !dmack_n) |-> ##[1:3] !data_oe_n_d)
		else $error("read data not driven after strobe fall");
	a_read_release: assert property ($rose(host_read_strobe_n) |-> ##[0:2] data_oe_n_d)
		else $error("data bus held after read strobe rise");
	a_iordy_stretch: assert property (!iordy |=> $stable(host_read_strobe_n) && $stable(host_write_strobe_n))
		else $error("strobe moved while iordy low");
	a_dmarq_drop: assert property ($fell(dmack_n) |-> ##[0:2] !dmarq)
		else $error("dmarq not negated after dmack");
	a_dmarq_wait: assert property ($fell(dmarq) && !dmarq_oe_n |-> !dmack_n || !$past(dmack_n))
		else $error("dmarq dropped before dmack");
	a_word_marker: assert property ($fell(iois16_n) |-> register_address_lines == host_port_pkg::ADDR_DATA || !dmack_n)
		else $error("iois16 low on a byte cycle");
	a_byte_width: assert property ($fell(host_read_strobe_n) && dmack_n && register_address_lines == host_port_pkg::ADDR_STATUS |-> ##2 iois16_n)
		else $error("iois16 low on status read");
	a_slave_diag: assert property (!pdiag_n |-> csel)
		else $error("pdiag driven by a master");
	a_dma_selects: assert property (!dmack_n |-> !cs0_n)
		else $error("chip select 0 negated during dma word");
endmodule // ata_host_port_checker
`default_nettype wire

// ---- verification/test_ata_device_host_port.sv ----
// self-checking bench: host end and device end joined by one interface
// assumes the bench drives both user sides at the falling clock edge
`timescale 1ns/100ps
`default_nettype none
module test_ata_device_host_port;
	logic        i_core_clk = 1'b0, i_rst = 1'b1;
	logic        i_req = 1'b0, i_write = 1'b0, i_dma = 1'b0, i_ctl = 1'b0, i_dev_reset = 1'b0;
	logic        i_slave_cfg = 1'b0, i_data_ready = 1'b1, i_dma_active = 1'b0, i_dma_more = 1'b0;
	logic        i_irq_set = 1'b0, i_diag_done = 1'b0, saw_wait = 1'b0;
	logic [2:0]  i_addr = 3'h0, i_mode = 3'h0, m;
	logic [15:0] i_wdata = 16'h0000, i_rd_word = 16'h0000, wq[$], cq[$];
	logic [7:0]  i_status = 8'h00;
	logic [31:0] seed = 32'h0000347d, v;
	logic        o_busy, o_done, o_irq, o_dmarq, o_diag_ok, o_cmd_valid, o_wr_valid, o_rd_take;
	logic        o_is_slave, o_host_reset;
	logic [15:0] o_rdata, o_wr_word;
	logic [7:0]  o_cmd;
	int          n_fail = 0, n_compared = 0, cyc = 0, k, n_take = 0;
	localparam logic [2:0] DAT = host_port_pkg::ADDR_DATA, ST = host_port_pkg::ADDR_STATUS;
	localparam logic [2:0] DH = host_port_pkg::ADDR_DRVHEAD;
	////////////////////////////////////////////////////////////////////////////////
	host_port_if bus_if ();
	disk_host_port disk_host_port_i (.i_core_clk, .i_rst, .bus(bus_if), .i_req, .i_write, .i_dma,
		.i_ctl, .i_addr, .i_wdata, .i_mode, .i_dev_reset, .i_slave_cfg, .o_busy, .o_done, .o_rdata,
		.o_irq, .o_dmarq, .o_diag_ok);
	disk_device_port disk_device_port_i (.i_core_clk, .i_rst, .bus(bus_if), .o_cmd_valid, .o_cmd,
		.i_data_ready, .i_rd_word, .o_wr_valid, .o_rd_take, .o_wr_word, .i_dma_active, .i_dma_more,
		.i_irq_set, .i_status, .i_diag_done, .o_is_slave, .o_host_reset);
	ata_host_port_checker ata_host_port_checker_i (.i_core_clk, .i_rst,
		.data_oe_n_d(bus_if.data_oe_n_d), .register_address_lines(bus_if.register_address_lines),
		.cs0_n(bus_if.cs0_n), .host_write_strobe_n(bus_if.host_write_strobe_n),
		.host_read_strobe_n(bus_if.host_read_strobe_n), .dmack_n(bus_if.dmack_n),
		.csel(bus_if.csel), .iordy(bus_if.iordy), .dmarq(bus_if.dmarq),
		.dmarq_oe_n(bus_if.dmarq_oe_n), .intrq(bus_if.intrq), .intrq_oe_n(bus_if.intrq_oe_n),
		.iois16_n(bus_if.iois16_n), .pdiag_n(bus_if.pdiag_n));
	////////////////////////////////////////////////////////////////////////////////
	// clock, and a cycle ceiling well above the few hundred cycles the run needs
	always #12.5 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			summarize();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// one host cycle; requests only from idle, the next waits for done
	task automatic xfer(input logic w, d, c, input logic [2:0] a, input logic [15:0] wd,
		input logic [2:0] md);
		@(negedge i_core_clk);
		{i_write, i_dma, i_ctl, i_addr, i_wdata, i_mode, i_req} = {w, d, c, a, wd, md, 1'b1};
		@(negedge i_core_clk);
		i_req = 1'b0;
		check("busy", o_busy, 1'b1); // cycle under way
		for (k = 0; k < 300 && o_done !== 1'b1; k++) @(negedge i_core_clk);
		check("done", o_done, 1'b1);
	endtask
	task automatic wait_rq();
		for (k = 0; k < 100 && o_dmarq !== 1'b1; k++) @(negedge i_core_clk);
		check("dmarq", {o_dmarq, bus_if.dmarq_oe_n}, 2'b10); // request driven when ready
	endtask
	// model side: every word and command the device reports must be the next one expected
	always @(negedge i_core_clk) begin
		if (bus_if.iordy === 1'b0) saw_wait = 1'b1;
		if (o_rd_take === 1'b1) n_take++;
		if (o_wr_valid === 1'b1) check("wr_word", o_wr_word, wq.size() ? wq.pop_front() : 'x);
		if (o_cmd_valid === 1'b1) check("cmd", o_cmd, cq.size() ? cq.pop_front() : 'x);
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge i_core_clk);
		@(negedge i_core_clk) i_rst = 1'b0;
		check("idle", {bus_if.dmarq_oe_n, bus_if.iois16_n, bus_if.data_oe_n_d}, 3'h7);
		// every pio mode: data write, data read, status read, command write
		for (m = 0; m < 5; m++) begin
			v = rnd();
			wq.push_back(v[15:0]);
			xfer(1'b1, 1'b0, 1'b0, DAT, v[15:0], m); // word write
			i_rd_word = v[31:16];
			xfer(1'b0, 1'b0, 1'b0, DAT, 16'h0000, m);
			check("pio_rd", o_rdata, v[31:16]); // word read
			i_status = v[23:16];
			xfer(1'b0, 1'b0, 1'b0, ST, 16'h0000, m);
			check("status", o_rdata, {8'h00, v[23:16]}); // byte read
			cq.push_back(v[7:0]);
			xfer(1'b1, 1'b0, 1'b0, ST, v[15:0], m); // upper byte ignored
		end
		// back end not ready: the cycle stretches
		v = rnd();
		i_rd_word = v[15:0];
		i_data_ready = 1'b0;
		fork
			begin
				repeat (12) @(negedge i_core_clk);
				i_data_ready = 1'b1;
			end
			xfer(1'b0, 1'b0, 1'b0, DAT, 16'h0000, 3'h4);
		join
		check("stretch", {saw_wait, o_rdata}, {1'b1, v[15:0]}); // wait state
		// raise, then clear by status read and by command write
		for (int j = 0; j < 2; j++) begin
			@(negedge i_core_clk) i_irq_set = 1'b1;
			@(negedge i_core_clk) i_irq_set = 1'b0;
			@(negedge i_core_clk);
			check("irq_up", o_irq, 1'b1); // raised
			if (j == 0) xfer(1'b0, 1'b0, 1'b0, ST, 16'h0000, 3'h0);
			else cq.push_back(8'hec);
			if (j == 1) xfer(1'b1, 1'b0, 1'b0, ST, 16'h00ec, 3'h0);
			repeat (14) @(negedge i_core_clk);
			check("irq_clr", o_irq, 1'b0); // cleared in 400 ns
		end
		xfer(1'b1, 1'b0, 1'b1, DH, 16'h0001 << host_port_pkg::NIEN_BIT, 3'h0);
		check("nien", bus_if.intrq_oe_n, 1'b1); // interrupts disabled
		xfer(1'b1, 1'b0, 1'b1, DH, 16'h0000, 3'h0);
		check("ien", bus_if.intrq_oe_n, 1'b0); // interrupts enabled
		// dma in every mode, write then read, the last word ends the command
		i_dma_active = 1'b1;
		i_dma_more = 1'b1;
		for (m = 0; m < 3; m++) begin
			v = rnd();
			wait_rq();
			wq.push_back(v[15:0]);
			xfer(1'b1, 1'b1, 1'b0, DAT, v[15:0], m); // dma word write
			wait_rq(); // reasserted while words remain
			i_rd_word = v[31:16];
			i_dma_more = (m != 3'h2);
			xfer(1'b0, 1'b1, 1'b0, DAT, 16'h0000, m);
			check("dma_rd", o_rdata, v[31:16]); // dma word read
		end
		repeat (6) @(negedge i_core_clk);
		check("dma_end", o_dmarq, 1'b0); // no more words
		i_dma_active = 1'b0;
		repeat (3) @(negedge i_core_clk);
		check("dma_off", bus_if.dmarq_oe_n, 1'b1); // released with no command
		// host reset, then run as slave
		i_dev_reset = 1'b1;
		repeat (3) @(negedge i_core_clk);
		check("host_rst", o_host_reset, 1'b1); // reset pin low
		i_dev_reset = 1'b0;
		i_slave_cfg = 1'b1;
		repeat (3) @(negedge i_core_clk);
		check("slave", o_is_slave, 1'b1); // slave address taken
		xfer(1'b1, 1'b0, 1'b0, DH, {8'h00, host_port_pkg::RST_DRVHEAD} | 16'h0010, 3'h0);
		v = rnd();
		i_rd_word = v[15:0];
		xfer(1'b0, 1'b0, 1'b0, DAT, 16'h0000, 3'h1);
		check("slave_rd", o_rdata, v[15:0]); // answers as drive 1
		i_diag_done = 1'b1;
		repeat (3) @(negedge i_core_clk);
		check("diag", {o_diag_ok, bus_if.pdiag_n}, 2'b10); // slave reports diagnostics
		// ten word reads: five pio, one stretched, three dma, one as slave
		check("rd_take", 16'(n_take), 16'h000a);
		summarize();
	end
endmodule // test_ata_device_host_port
`default_nettype wire
